// [uies_pkg.sv]
// constants for the uart interrupt enable and status block
package uies_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_MASK = 8'h00;
  localparam logic [7:0] ADDR_SOURCE = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_LINE = 8'h0C;
  localparam logic [7:0] ADDR_MODEM = 8'h10;
  localparam logic [7:0] ADDR_RXHOLD = 8'h14;
  localparam logic [7:0] ADDR_TXHOLD = 8'h18;
  // reset values
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [5:0] CTRL_RST = 6'h00;
  // mask bit positions
  localparam int MB_RXD = 0;
  localparam int MB_TXR = 1;
  localparam int MB_LINE = 2;
  localparam int MB_MODEM = 3;
  localparam int MB_SLEEP = 4;
  localparam int MB_XOFF = 5;
  localparam int MB_RTS = 6;
  localparam int MB_CTS = 7;
  // enhanced-gated mask bits
  localparam logic [7:0] MASK_ENH = 8'hF0;
  // control bit positions
  localparam int CB_FIFO = 0;
  localparam int CB_ENH = 1;
  localparam int CB_RS485 = 2;
  localparam int CB_ERRNOW = 3;
  localparam int CB_ARTS = 4;
  localparam int CB_ACTS = 5;
  // source codes, bits 5:0
  localparam logic [5:0] SRC_LINE = 6'h06;
  localparam logic [5:0] SRC_TOUT = 6'h0C;
  localparam logic [5:0] SRC_RXD = 6'h04;
  localparam logic [5:0] SRC_TXR = 6'h02;
  localparam logic [5:0] SRC_MODEM = 6'h00;
  localparam logic [5:0] SRC_XOFF = 6'h10;
  localparam logic [5:0] SRC_FLOW = 6'h20;
  localparam logic [5:0] SRC_NONE = 6'h01;
  localparam logic [1:0] FIFO_ON_BITS = 2'h3;
  // receive time-out: four characters plus twelve bits
  localparam logic [2:0] TOUT_CHARS = 3'h4;
  localparam logic [6:0] TOUT_BITS = 7'h0C;
  // fifo depth field width
  localparam int LVL_W = 7;
endpackage : uies_pkg

// [uies_top.sv]
// interrupt enable, prioritised source and line state logic of one uart channel
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps

module uies_top (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // receiver side
  input wire logic rx_push,
  input wire logic [uies_pkg::LVL_W-1:0] rx_level,
  input wire logic [uies_pkg::LVL_W-1:0] rx_trigger,
  input wire logic [7:0] rx_head_data,
  input wire logic [2:0] rx_head_err,
  input wire logic rx_any_err,
  input wire logic rx_overrun,
  input wire logic rx_err_push,
  input wire logic bit_tick,
  input wire logic [3:0] char_bits,
  output logic rx_pop,
  // transmitter side
  input wire logic [uies_pkg::LVL_W-1:0] tx_level,
  input wire logic [uies_pkg::LVL_W-1:0] tx_trigger,
  input wire logic tx_shifter_empty,
  output logic tx_push,
  output logic [7:0] tx_data,
  // modem and flow control
  input wire logic [3:0] modem_delta,
  input wire logic [3:0] modem_lines,
  input wire logic cts_n_pin,
  input wire logic rts_n_level,
  input wire logic xoff_match,
  input wire logic xon_match,
  input wire logic special_match,
  // status out
  output logic fifo_en,
  output logic sleep_en,
  output logic irq
);
  import uies_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  logic [31:0] prdata_ff;
  logic [7:0] mask_ff, tx_data_ff;
  logic [6:0] tout_cnt_ff;
  logic [5:0] ctrl_ff, code_ff;
  logic [3:0] modem_ff;
  logic [2:0] cts_sync_ff;
  logic irq_ff, data_ready_ff, overrun_ff, line_int_ff, txr_int_ff, tout_int_ff;
  logic xoff_int_ff, spec_int_ff, rts_int_ff, cts_int_ff, cts_n_ff, rts_n_ff;
  logic txr_cond_ff, shift_empty_ff, defer_chk_ff;

  logic setup_ph, access, wr_acc, rd_acc, mapped, enh;
  logic rd_line, rd_modem, rd_rxhold, rd_source, wr_txhold, wr_mask;
  logic rxd_cond, txr_cond, all_empty, cts_rise, rts_rise;
  logic [7:0] nxt_mask, mask_eff, line_state, source_val, pend;
  logic [6:0] tout_limit;
  logic [5:0] nxt_code;

  // apb decode; zero wait states, data prepared in setup phase
  assign setup_ph = psel & ~penable;
  assign access = psel & penable;
  assign wr_acc = access & pwrite & mapped;
  assign rd_acc = access & ~pwrite & mapped;
  assign mapped = hit(paddr, ADDR_MASK) | hit(paddr, ADDR_SOURCE) | hit(paddr, ADDR_CTRL)
                | hit(paddr, ADDR_LINE) | hit(paddr, ADDR_MODEM) | hit(paddr, ADDR_RXHOLD)
                | hit(paddr, ADDR_TXHOLD);
  assign pready = access;
  assign pslverr = access & ~mapped;
  assign prdata = prdata_ff;

  assign rd_line = rd_acc & hit(paddr, ADDR_LINE);
  assign rd_modem = rd_acc & hit(paddr, ADDR_MODEM);
  assign rd_rxhold = rd_acc & hit(paddr, ADDR_RXHOLD);
  assign rd_source = rd_acc & hit(paddr, ADDR_SOURCE);
  assign wr_txhold = wr_acc & hit(paddr, ADDR_TXHOLD);
  assign wr_mask = wr_acc & hit(paddr, ADDR_MASK);

  assign rx_pop = rd_rxhold;
  assign tx_push = wr_txhold;
  assign tx_data = tx_data_ff;

  assign enh = ctrl_ff[CB_ENH];
  assign fifo_en = ctrl_ff[CB_FIFO];
  // upper mask bits act only with the enhanced enable set
  assign mask_eff = enh ? mask_ff : (mask_ff & ~MASK_ENH);
  assign sleep_en = mask_eff[MB_SLEEP];
  assign irq = irq_ff;

  // enhanced bits keep their value when written without the enhanced enable
  assign nxt_mask = enh ? pwdata[7:0]
                  : ((pwdata[7:0] & ~MASK_ENH) | (mask_ff & MASK_ENH));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_ff <= MASK_RST;
    end else if (wr_mask) begin
      mask_ff <= nxt_mask;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= CTRL_RST;
    end else if (wr_acc && hit(paddr, ADDR_CTRL)) begin
      ctrl_ff <= pwdata[5:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_data_ff <= 8'h00;
    end else if (wr_txhold) begin
      tx_data_ff <= pwdata[7:0];
    end
  end

  // line state word
  assign all_empty = (tx_level == '0) & tx_shifter_empty;
  assign line_state = {rx_any_err, all_empty, (tx_level == '0), rx_head_err,
                       overrun_ff, data_ready_ff};

  // receive data ready: set by a push, cleared once the fifo runs dry
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_ready_ff <= 1'b0;
    end else if (rx_push) begin
      data_ready_ff <= 1'b1;
    end else if (rx_level == '0) begin
      data_ready_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      overrun_ff <= 1'b0;
    end else if (rx_overrun) begin
      overrun_ff <= 1'b1;
    end else if (rd_line) begin
      overrun_ff <= 1'b0;
    end
  end

  // after a pop the next head byte's error shows one cycle later
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      defer_chk_ff <= 1'b0;
    end else begin
      defer_chk_ff <= rd_rxhold;
    end
  end

  // line status source; the event wins over a clearing read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      line_int_ff <= 1'b0;
    end else if (rx_overrun
                 || (ctrl_ff[CB_ERRNOW] && rx_err_push)
                 || (!ctrl_ff[CB_ERRNOW] && defer_chk_ff && rx_head_err != 3'h0)) begin
      line_int_ff <= 1'b1;
    end else if (rd_line) begin
      line_int_ff <= 1'b0;
    end
  end

  // receive data condition is a level, no latching
  assign rxd_cond = fifo_en ? (rx_level >= rx_trigger) : (rx_level != '0);

  // transmit ready condition; rs485 direction waits for a drained shifter
  assign txr_cond = ctrl_ff[CB_RS485] ? all_empty
                  : (fifo_en ? ((tx_level < tx_trigger) || (tx_level == '0))
                             : (tx_level == '0));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txr_cond_ff <= 1'b0;
      shift_empty_ff <= 1'b0;
    end else begin
      txr_cond_ff <= txr_cond;
      shift_empty_ff <= tx_shifter_empty;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txr_int_ff <= 1'b0;
    end else if ((txr_cond && !txr_cond_ff)
                 || (wr_mask && pwdata[MB_TXR] && !mask_ff[MB_TXR] && txr_cond)) begin
      txr_int_ff <= 1'b1;
    end else if (wr_txhold || (rd_source && code_ff == SRC_TXR)) begin
      txr_int_ff <= 1'b0;
    end
  end

  // time-out: restarted by any fifo activity, counts bit times while data waits
  assign tout_limit = 7'(7'(TOUT_CHARS) * 7'(char_bits)) + TOUT_BITS;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tout_cnt_ff <= 7'h00;
    end else if (rx_push || rd_rxhold || !fifo_en || rx_level == '0) begin
      tout_cnt_ff <= 7'h00;
    end else if (bit_tick && tout_cnt_ff != tout_limit) begin
      tout_cnt_ff <= tout_cnt_ff + 7'h01;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tout_int_ff <= 1'b0;
    end else if (bit_tick && fifo_en && rx_level != '0 && !rx_push && !rd_rxhold
                 && tout_cnt_ff == tout_limit - 7'h01) begin
      tout_int_ff <= 1'b1;
    end else if (rd_rxhold) begin
      tout_int_ff <= 1'b0;
    end
  end

  // modem change bits, sticky until the modem state read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      modem_ff <= 4'h0;
    end else begin
      modem_ff <= (rd_modem ? 4'h0 : modem_ff) | modem_delta;
    end
  end

  // xoff and special character sources
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      xoff_int_ff <= 1'b0;
    end else if (xoff_match) begin
      xoff_int_ff <= 1'b1;
    end else if (xon_match || (rd_source && code_ff == SRC_XOFF)) begin
      xoff_int_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      spec_int_ff <= 1'b0;
    end else if (special_match) begin
      spec_int_ff <= 1'b1;
    end else if (rx_push || (rd_source && code_ff == SRC_XOFF)) begin
      spec_int_ff <= 1'b0;
    end
  end

  // cts pin crosses in; the second and third stages must agree
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cts_sync_ff <= 3'b111; // idle level of the pin, so no false rise after reset
    end else begin
      cts_sync_ff <= {cts_sync_ff[1:0], cts_n_pin};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cts_n_ff <= 1'b1;
      rts_n_ff <= 1'b1;
    end else begin
      if (cts_sync_ff[1] == cts_sync_ff[2]) begin
        cts_n_ff <= cts_sync_ff[2];
      end
      rts_n_ff <= rts_n_level;
    end
  end

  assign cts_rise = (cts_sync_ff[1] == cts_sync_ff[2]) & cts_sync_ff[2] & ~cts_n_ff;
  assign rts_rise = rts_n_level & ~rts_n_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rts_int_ff <= 1'b0;
    end else if (rts_rise && ctrl_ff[CB_ARTS]) begin
      rts_int_ff <= 1'b1;
    end else if (rd_modem) begin
      rts_int_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cts_int_ff <= 1'b0;
    end else if (cts_rise && ctrl_ff[CB_ACTS]) begin
      cts_int_ff <= 1'b1;
    end else if (rd_modem) begin
      cts_int_ff <= 1'b0;
    end
  end

  // masked pending sources, index is priority level minus one
  assign pend[0] = line_int_ff & mask_eff[MB_LINE];
  assign pend[1] = tout_int_ff & mask_eff[MB_RXD];
  assign pend[2] = rxd_cond & mask_eff[MB_RXD];
  assign pend[3] = txr_int_ff & mask_eff[MB_TXR];
  assign pend[4] = (modem_ff != 4'h0) & mask_eff[MB_MODEM];
  assign pend[5] = (xoff_int_ff | spec_int_ff) & mask_eff[MB_XOFF];
  assign pend[6] = (rts_int_ff & mask_eff[MB_RTS])
                 | (cts_int_ff & mask_eff[MB_CTS]);
  assign pend[7] = 1'b0;

  // only the most urgent source is reported
  always_comb begin
    nxt_code = SRC_NONE;
    if (pend[0]) begin
      nxt_code = SRC_LINE;
    end else if (pend[1]) begin
      nxt_code = SRC_TOUT;
    end else if (pend[2]) begin
      nxt_code = SRC_RXD;
    end else if (pend[3]) begin
      nxt_code = SRC_TXR;
    end else if (pend[4]) begin
      nxt_code = SRC_MODEM;
    end else if (pend[5]) begin
      nxt_code = SRC_XOFF;
    end else if (pend[6]) begin
      nxt_code = SRC_FLOW;
    end
  end

  assign source_val = {(fifo_en ? FIFO_ON_BITS : 2'b00), nxt_code};

  // the code seen by software is frozen at setup so the clearing read
  // acts on the source it returned, not on one raised in between
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      code_ff <= SRC_NONE;
    end else if (setup_ph && hit(paddr, ADDR_SOURCE)) begin
      code_ff <= nxt_code;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (pend != 8'h00);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata_ff <= 32'h0000_0000;
      if (hit(paddr, ADDR_MASK)) begin
        prdata_ff[7:0] <= mask_eff;
      end else if (hit(paddr, ADDR_SOURCE)) begin
        prdata_ff[7:0] <= source_val;
      end else if (hit(paddr, ADDR_CTRL)) begin
        prdata_ff[5:0] <= ctrl_ff;
      end else if (hit(paddr, ADDR_LINE)) begin
        prdata_ff[7:0] <= line_state;
      end else if (hit(paddr, ADDR_MODEM)) begin
        prdata_ff[7:0] <= {modem_lines, modem_ff};
      end else if (hit(paddr, ADDR_RXHOLD)) begin
        prdata_ff[7:0] <= rx_head_data;
      end
    end
  end
endmodule : uies_top

// [uies_assertions.sv]
// checker for the uart interrupt enable and status block
`timescale 1ns/1ps
module uies_chk
  import uies_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // status
  input wire logic rx_pop,
  input wire logic tx_push,
  input wire logic fifo_en,
  input wire logic sleep_en,
  input wire logic irq
);
  logic acc;
  logic enh_ff;
  logic [7:0] msk_ff;
  assign acc = psel && penable;
  // shadow copies, so mask gating is judged without the body
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) enh_ff <= 1'h0;
    else if (acc && pwrite && paddr == ADDR_CTRL) enh_ff <= pwdata[CB_ENH];
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) msk_ff <= MASK_RST;
    else if (acc && pwrite && paddr == ADDR_MASK)
      msk_ff <= enh_ff ? pwdata[7:0] : {msk_ff[7:4], pwdata[3:0]};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_fifo_status: assert property (
    acc && !pwrite && paddr == ADDR_SOURCE |-> prdata[7:6] == {2{fifo_en}})
    else $error("source fifo bits wrong");
  a_fifo_enable: assert property (
    acc && pwrite && paddr == ADDR_CTRL |=> fifo_en == $past(pwdata[CB_FIFO]))
    else $error("fifo enable not taken");
  a_tx_strobe: assert property (
    tx_push == (acc && pwrite && paddr == ADDR_TXHOLD))
    else $error("tx push strobe wrong");
  a_rx_strobe: assert property (
    rx_pop == (acc && !pwrite && paddr == ADDR_RXHOLD))
    else $error("rx pop strobe wrong");
  a_mask_readback: assert property (
    acc && !pwrite && paddr == ADDR_MASK |->
    prdata[7:0] == (enh_ff ? msk_ff : {4'h0, msk_ff[3:0]}))
    else $error("mask readback wrong");
  a_sleep_gate: assert property (
    sleep_en == (enh_ff && msk_ff[MB_SLEEP]))
    else $error("sleep enable gating wrong");
  a_irq_masked: assert property (
    msk_ff == 8'h00 |=> !irq)
    else $error("irq with all masked");
  a_src_none: assert property (
    acc && !pwrite && paddr == ADDR_SOURCE && $past(msk_ff) == 8'h00 |->
    prdata[5:0] == SRC_NONE)
    else $error("source not idle when masked");
endmodule : uies_chk

bind uies_top uies_chk u_chk (
  .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .rx_pop(rx_pop),
  .tx_push(tx_push), .fifo_en(fifo_en), .sleep_en(sleep_en), .irq(irq));

// [uies_host.sv]
// host model: apb master servicing the interrupt registers
`timescale 1ns/1ps
module uies_host (
  // clock
  input wire logic clk,
  // apb master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // holds every qualifier until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1 && n < 16) begin
      @(posedge clk);
      n++;
    end
    if (pready !== 1'h1) begin
      tb.fail_count++;
      tb.end_sim();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // released lines must not look still valid
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : uies_host

// [tb.sv]
// testbench for the uart interrupt enable and status block
`timescale 1ns/1ps
module tb;
  import uies_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] x; logic e;} uies_row_s;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, last_e;
  logic [7:0] paddr, tx_data, rx_head_data;
  logic [31:0] pwdata, prdata;
  logic [6:0] ev;
  logic [LVL_W-1:0] rx_level, rx_trigger, tx_level, tx_trigger;
  logic [2:0] rx_head_err;
  logic [3:0] char_bits, modem_delta, modem_lines;
  logic rx_any_err, tx_shifter_empty, cts_n_pin, rts_n_level;
  logic rx_pop, tx_push, fifo_en, sleep_en, irq;
  int fail_count, total_checks;
  uies_row_s rows [12];
  uies_host host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  uies_top DUT (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_push(ev[0]), .rx_level(rx_level), .rx_trigger(rx_trigger),
    .rx_head_data(rx_head_data), .rx_head_err(rx_head_err), .rx_any_err(rx_any_err),
    .rx_overrun(ev[1]), .rx_err_push(ev[2]), .bit_tick(ev[6]), .char_bits(char_bits),
    .rx_pop(rx_pop), .tx_level(tx_level), .tx_trigger(tx_trigger),
    .tx_shifter_empty(tx_shifter_empty), .tx_push(tx_push), .tx_data(tx_data),
    .modem_delta(modem_delta), .modem_lines(modem_lines), .cts_n_pin(cts_n_pin),
    .rts_n_level(rts_n_level), .xoff_match(ev[3]), .xon_match(ev[4]),
    .special_match(ev[5]), .fifo_en(fifo_en), .sleep_en(sleep_en), .irq(irq));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    host.xfer(1'h1, a, {24'h00_0000, d}, r, last_e);
  endtask : wr
  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] x);
    logic [31:0] r;
    host.xfer(1'h0, a, 32'h0000_0000, r, last_e);
    chk(n, {24'h00_0000, x}, r);
  endtask : rc
  task automatic src(input logic [7:0] x);
    repeat (3) @(posedge clk);
    rc("source", ADDR_SOURCE, x);
  endtask : src
  task automatic pz(input logic [6:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 7'h00;
  endtask : pz
  task automatic end_sim;
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  initial begin
    arst_n = 1'h0;
    ev = 7'h00;
    {rx_level, tx_level, rx_trigger, tx_trigger} = {7'h00, 7'h0A, 7'h08, 7'h04};
    {rx_head_data, rx_head_err, rx_any_err, char_bits} = {8'h5A, 3'h0, 1'h0, 4'hA};
    {modem_delta, modem_lines, cts_n_pin, rts_n_level} = {4'h0, 4'hA, 1'h0, 1'h0};
    tx_shifter_empty = 1'h0;
    rows = '{'{1'h0, ADDR_MASK, 8'h00, MASK_RST, 1'h0}, '{1'h0, ADDR_SOURCE, 8'h00, 8'h01, 1'h0},
      '{1'h1, ADDR_MASK, 8'hF0, 8'h00, 1'h0}, '{1'h0, ADDR_MASK, 8'h00, 8'h00, 1'h0},
      '{1'h1, ADDR_CTRL, 8'h03, 8'h00, 1'h0}, '{1'h1, ADDR_MASK, 8'hF0, 8'h00, 1'h0},
      '{1'h0, ADDR_MASK, 8'h00, 8'hF0, 1'h0}, '{1'h0, ADDR_SOURCE, 8'h00, 8'hC1, 1'h0},
      '{1'h1, ADDR_SOURCE, 8'hFF, 8'h00, 1'h0}, '{1'h1, ADDR_MASK, 8'h00, 8'h00, 1'h0},
      '{1'h0, 8'h1C, 8'h00, 8'h00, 1'h1}, '{1'h1, ADDR_CTRL, 8'h00, 8'h00, 1'h0}};
    repeat (16) @(posedge clk);
    arst_n <= 1'h1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else begin
        rc("row read", rows[i].a, rows[i].x);
        chk("slverr", 32'(rows[i].e), 32'(last_e));
      end
    end
    wr(ADDR_CTRL, 8'h01);
    wr(ADDR_MASK, 8'h0F);
    rx_level <= 7'h08;
    modem_delta <= 4'h1;
    pz(7'h03);
    modem_delta <= 4'h0;
    src(8'hC6);
    chk("irq", 32'h0000_0001, 32'(irq));
    rc("line", ADDR_LINE, 8'h03);
    src(8'hC4);
    rx_level <= 7'h07;
    src(8'hC0);
    rc("modem", ADDR_MODEM, 8'hA1);
    src(8'hC1);
    // mask cleared: polled use of line state
    wr(ADDR_MASK, 8'h00);
    {rx_head_err, rx_any_err, tx_level, tx_shifter_empty} <= {3'h5, 1'h1, 7'h00, 1'h1};
    rc("line", ADDR_LINE, 8'hF5);
    rx_level <= 7'h00;
    rc("line", ADDR_LINE, 8'hF4);
    wr(ADDR_MASK, 8'h02);
    src(8'hC2);
    src(8'hC1);
    wr(ADDR_MASK, 8'h00);
    wr(ADDR_MASK, 8'h02);
    src(8'hC2);
    src(8'hC1);
    tx_level <= 7'h0A;
    repeat (2) @(posedge clk);
    tx_level <= 7'h00;
    repeat (3) @(posedge clk);
    chk("irq", 32'h0000_0001, 32'(irq));
    wr(ADDR_TXHOLD, 8'hA5);
    src(8'hC1);
    chk("tx_data", 32'h0000_00A5, {24'h00_0000, tx_data});
    wr(ADDR_CTRL, 8'h05);
    {tx_shifter_empty, tx_level} <= {1'h0, 7'h0A};
    repeat (2) @(posedge clk);
    tx_level <= 7'h00;
    src(8'hC1);
    tx_shifter_empty <= 1'h1;
    src(8'hC2);
    wr(ADDR_CTRL, 8'h01);
    wr(ADDR_MASK, 8'h01);
    rx_level <= 7'h01;
    pz(7'h01);
    repeat (int'(TOUT_CHARS) * 10 + int'(TOUT_BITS) - 1) pz(7'h40);
    src(8'hC1);
    pz(7'h40);
    src(8'hCC);
    rc("rx hold", ADDR_RXHOLD, 8'h5A);
    src(8'hC1);
    wr(ADDR_CTRL, 8'h33);
    wr(ADDR_MASK, 8'hC0);
    cts_n_pin <= 1'h1;
    repeat (4) @(posedge clk);
    src(8'hE0);
    rc("modem", ADDR_MODEM, 8'hA0);
    src(8'hC1);
    rts_n_level <= 1'h1;
    src(8'hE0);
    rc("modem", ADDR_MODEM, 8'hA0);
    src(8'hC1);
    wr(ADDR_CTRL, 8'h03);
    wr(ADDR_MASK, 8'h20);
    pz(7'h08);
    repeat (3) @(posedge clk);
    chk("irq", 32'h0000_0001, 32'(irq));
    pz(7'h10);
    repeat (3) @(posedge clk);
    chk("irq", 32'h0000_0000, 32'(irq));
    pz(7'h20);
    src(8'hD0);
    src(8'hC1);
    wr(ADDR_CTRL, 8'h09);
    rc("line", ADDR_LINE, 8'hF5);
    wr(ADDR_MASK, 8'h04);
    pz(7'h04);
    src(8'hC6);
    rc("line", ADDR_LINE, 8'hF5);
    src(8'hC1);
    arst_n <= 1'h0;
    repeat (2) @(posedge clk);
    chk("fifo_en", 32'h0000_0000, 32'(fifo_en));
    chk("irq", 32'h0000_0000, 32'(irq));
    arst_n <= 1'h1;
    rc("mask", ADDR_MASK, MASK_RST);
    src(8'h01);
    end_sim();
  end
endmodule : tb
